// ### rtl/dtc_pkg.sv
// Functional notes
// [RULE_01] Timer function counts one step per machine cycle of 12 clocks.
// [RULE_02] Counter function samples count pin once per machine cycle; high then low counts.
// [RULE_03] A detected falling edge shows in the count at the next update phase.
// [RULE_04] Edge recognition spans two machine cycles, so pin rate is clock/24 at most.
// [RULE_05] Source should hold each count pin level one full machine cycle.
// [RULE_06] Function-select bit chooses machine cycles (0) or count pin edges (1).
// [RULE_07] Counting needs run bit set and gate bit clear or gate pin high.
// [RULE_08] Gate bit of timer b is mode bit 7, of timer a bit 3.
// [RULE_09] Mode register: timer b fields upper nibble, timer a lower nibble.
// [RULE_10] Mode 00: high register counts through divide-by-32 prescaler in low bits 4:0.
// [RULE_11] Mode 00: 13-bit count; low bits 7:5 are left untouched and meaningless.
// [RULE_12] Mode 01: high and low registers form one 16-bit counter.
// [RULE_13] Mode 10: low register counts 8 bits and reloads from high on overflow.
// [RULE_14] Mode 11 on timer a: low uses a controls, high times with b controls.
// [RULE_15] Mode 11 on timer b stops timer b.
// [RULE_16] Rollover from all ones to zero sets the timer overflow flag.
// [RULE_17] Setting a run bit leaves the count registers unchanged.
// [RULE_18] Auto-reload leaves the high register unchanged.
// [RULE_19] In split mode the high timer of a uses run bit b and flag b.
// [RULE_20] In split mode timer b starts and stops by leaving or entering mode 11.
// [RULE_21] Overflow flag stays set until cleared; counting carries on from zero, or from the reloaded high value in mode 10.
`default_nettype none
package dtc_pkg;
  localparam int unsigned DTC_OSC_PER_MC = 12;
  localparam logic [3:0] DTC_PH_LAST = 4'(DTC_OSC_PER_MC - 1);
  // State 3 phase 1 and state 5 phase 2 as clock index in a machine cycle
  localparam logic [3:0] DTC_PH_UPDATE = 4'h4;
  localparam logic [3:0] DTC_PH_SAMPLE = 4'h9;
  // Register indices; byte address is four times the index
  localparam int unsigned DTC_IDX_CTRL = 'h88;
  localparam int unsigned DTC_IDX_MODE = 'h89;
  localparam int unsigned DTC_IDX_LOW_A = 'h8a;
  localparam int unsigned DTC_IDX_LOW_B = 'h8b;
  localparam int unsigned DTC_IDX_HIGH_A = 'h8c;
  localparam int unsigned DTC_IDX_HIGH_B = 'h8d;
  localparam logic [11:0] DTC_ADDR_CTRL = 12'(DTC_IDX_CTRL * 4);
  localparam logic [11:0] DTC_ADDR_MODE = 12'(DTC_IDX_MODE * 4);
  localparam logic [11:0] DTC_ADDR_LOW_A = 12'(DTC_IDX_LOW_A * 4);
  localparam logic [11:0] DTC_ADDR_LOW_B = 12'(DTC_IDX_LOW_B * 4);
  localparam logic [11:0] DTC_ADDR_HIGH_A = 12'(DTC_IDX_HIGH_A * 4);
  localparam logic [11:0] DTC_ADDR_HIGH_B = 12'(DTC_IDX_HIGH_B * 4);
  // Mode register fields
  localparam int unsigned DTC_GATE_B = 7;
  localparam int unsigned DTC_CT_B = 6;
  localparam int unsigned DTC_GATE_A = 3;
  localparam int unsigned DTC_CT_A = 2;
  // Control register fields
  localparam int unsigned DTC_FLAG_B = 7;
  localparam int unsigned DTC_RUN_B = 6;
  localparam int unsigned DTC_FLAG_A = 5;
  localparam int unsigned DTC_RUN_A = 4;
  localparam logic [7:0] DTC_MODE_RESET = 8'h00;
  localparam logic [7:0] DTC_COUNT_RESET = 8'h00;
  localparam logic [1:0] DTC_M_13BIT = 2'h0;
  localparam logic [1:0] DTC_M_16BIT = 2'h1;
  localparam logic [1:0] DTC_M_RELOAD = 2'h2;
  localparam logic [1:0] DTC_M_SPLIT = 2'h3;
  localparam logic [1:0] DTC_RESP_OKAY = 2'h0;
  localparam logic [1:0] DTC_RESP_SLVERR = 2'h2;
endpackage : dtc_pkg
`default_nettype wire

// ### rtl/dtc_top.sv
`default_nettype none
module dtc_top
  import dtc_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Pins
  input wire logic count_pin_a_i,
  input wire logic count_pin_b_i,
  input wire logic gate_pin_a_i,
  input wire logic gate_pin_b_i,
  // Flag acknowledge and flags
  input wire logic flag_ack_a_i,
  input wire logic flag_ack_b_i,
  output logic overflow_flag_a_o,
  output logic overflow_flag_b_o
);
  if (ADDR_W < 12) begin : g_chk
    $error("ADDR_W must be at least 12");
  end

  // ---------------------------------------------
  // Step of one timer: {overflow, high, low}
  // ---------------------------------------------
  function automatic logic [16:0] dtc_step(input logic [1:0] m, input logic [7:0] hi, input logic [7:0] lo);
    logic [12:0] c13;
    logic [15:0] c16;
    logic [7:0] c8;
    c13 = {hi, lo[4:0]} + 13'h1;
    c16 = {hi, lo} + 16'h1;
    c8 = lo + 8'h1;
    case (m)
      DTC_M_13BIT: dtc_step = {&{hi, lo[4:0]}, c13[12:5], lo[7:5], c13[4:0]}; // [RULE_10] [RULE_11]
      DTC_M_16BIT: dtc_step = {&{hi, lo}, c16}; // [RULE_12]
      DTC_M_RELOAD: dtc_step = {&lo, hi, (&lo) ? hi : c8}; // [RULE_13] [RULE_18]
      default: dtc_step = {&lo, hi, c8}; // [RULE_14]
    endcase
  endfunction : dtc_step

  // ---------------------------------------------
  // State
  // ---------------------------------------------
  logic [3:0] phase;
  logic [7:0] timer_mode_control;
  logic run_bit_a, run_bit_b, overflow_flag_a, overflow_flag_b;
  logic [7:0] low_register_a, high_register_a, low_b, high_b;
  logic samp_a, samp_b, pend_a, pend_b;
  logic aw_v, w_v;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // ---------------------------------------------
  // Machine cycle timing
  // ---------------------------------------------
  wire upd = (phase == DTC_PH_UPDATE);
  wire smp = (phase == DTC_PH_SAMPLE);
  always_ff @(posedge clk_i) begin
    if (reset_i || phase == DTC_PH_LAST) begin
      phase <= 4'h0; // [RULE_01]
    end else begin
      phase <= phase + 4'h1;
    end
  end

  // ---------------------------------------------
  // Count pin sampling and edge detect
  // ---------------------------------------------
  wire fall_a = smp && samp_a && !count_pin_a_i; // [RULE_02] [RULE_04]
  wire fall_b = smp && samp_b && !count_pin_b_i;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      samp_a <= 1'b0;
      samp_b <= 1'b0;
      pend_a <= 1'b0;
      pend_b <= 1'b0;
    end else begin
      if (smp) begin
        samp_a <= count_pin_a_i; // [RULE_02]
        samp_b <= count_pin_b_i;
      end
      pend_a <= fall_a || (pend_a && !upd); // [RULE_03]
      pend_b <= fall_b || (pend_b && !upd);
    end
  end

  // ---------------------------------------------
  // Count enables
  // ---------------------------------------------
  wire [1:0] mode_a = timer_mode_control[1:0];
  wire [1:0] mode_b = timer_mode_control[5:4];
  wire split = (mode_a == DTC_M_SPLIT);
  wire gate_a = timer_mode_control[DTC_GATE_A]; // [RULE_08] [RULE_09]
  wire gate_b = timer_mode_control[DTC_GATE_B];
  wire en_a = run_bit_a && (!gate_a || gate_pin_a_i); // [RULE_07]
  wire en_b = split ? 1'b1 : run_bit_b && (!gate_b || gate_pin_b_i); // [RULE_20]
  wire src_a = timer_mode_control[DTC_CT_A] ? pend_a : 1'b1; // [RULE_06]
  wire src_b = timer_mode_control[DTC_CT_B] ? pend_b : 1'b1;
  wire tick_a = upd && en_a && src_a;
  wire tick_b = upd && en_b && src_b && (mode_b != DTC_M_SPLIT); // [RULE_15]
  wire tick_ha = upd && split && run_bit_b; // [RULE_14] [RULE_19]
  wire [16:0] step_a = dtc_step(mode_a, high_register_a, low_register_a);
  wire [16:0] step_b = dtc_step(mode_b, high_b, low_b);
  wire ovf_a = tick_a && step_a[16]; // [RULE_16]
  wire ovf_ha = tick_ha && (&high_register_a);
  wire ovf_b = split ? ovf_ha : tick_b && step_b[16]; // [RULE_19]

  // ---------------------------------------------
  // AXI4-Lite write path
  // ---------------------------------------------
  wire wr_go = aw_v && w_v && !s_axi_bvalid_o;
  wire wr_b0 = wr_go && w_strb[0];
  wire [7:0] wd = w_data[7:0];
  wire wa_ctrl = (aw_addr[11:0] == DTC_ADDR_CTRL);
  wire wa_mode = (aw_addr[11:0] == DTC_ADDR_MODE);
  wire wa_la = (aw_addr[11:0] == DTC_ADDR_LOW_A);
  wire wa_lb = (aw_addr[11:0] == DTC_ADDR_LOW_B);
  wire wa_ha = (aw_addr[11:0] == DTC_ADDR_HIGH_A);
  wire wa_hb = (aw_addr[11:0] == DTC_ADDR_HIGH_B);
  wire wa_hit = wa_ctrl || wa_mode || wa_la || wa_lb || wa_ha || wa_hb;
  wire wr_ctrl = wr_b0 && wa_ctrl;
  assign s_axi_awready_o = !aw_v && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_v && !s_axi_bvalid_o;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      aw_v <= 1'b0;
      w_v <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= DTC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_v <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end else if (wr_go) begin
        aw_v <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_v <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end else if (wr_go) begin
        w_v <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wa_hit ? DTC_RESP_OKAY : DTC_RESP_SLVERR;
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // ---------------------------------------------
  // Registers and counters
  // ---------------------------------------------
  wire [7:0] next_low_a = (wr_b0 && wa_la) ? wd : tick_a ? step_a[7:0] : low_register_a; // [RULE_21]
  wire [7:0] next_high_a = (wr_b0 && wa_ha) ? wd : tick_ha ? high_register_a + 8'h1
                         : (tick_a && !split) ? step_a[15:8] : high_register_a;
  wire [7:0] next_low_b = (wr_b0 && wa_lb) ? wd : tick_b ? step_b[7:0] : low_b;
  wire [7:0] next_high_b = (wr_b0 && wa_hb) ? wd : tick_b ? step_b[15:8] : high_b;
  // Hardware set wins over software or acknowledge clear
  wire next_flag_a = ovf_a || ((wr_ctrl ? wd[DTC_FLAG_A] : overflow_flag_a) && !flag_ack_a_i); // [RULE_21]
  wire next_flag_b = ovf_b || ((wr_ctrl ? wd[DTC_FLAG_B] : overflow_flag_b) && !flag_ack_b_i);
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      timer_mode_control <= DTC_MODE_RESET;
      run_bit_a <= 1'b0;
      run_bit_b <= 1'b0;
      overflow_flag_a <= 1'b0;
      overflow_flag_b <= 1'b0;
      low_register_a <= DTC_COUNT_RESET;
      high_register_a <= DTC_COUNT_RESET;
      low_b <= DTC_COUNT_RESET;
      high_b <= DTC_COUNT_RESET;
    end else begin
      if (wr_b0 && wa_mode) begin
        timer_mode_control <= wd; // [RULE_09]
      end
      if (wr_ctrl) begin
        run_bit_a <= wd[DTC_RUN_A]; // [RULE_17]
        run_bit_b <= wd[DTC_RUN_B];
      end
      overflow_flag_a <= next_flag_a; // [RULE_16]
      overflow_flag_b <= next_flag_b;
      low_register_a <= next_low_a;
      high_register_a <= next_high_a;
      low_b <= next_low_b;
      high_b <= next_high_b;
    end
  end
  assign overflow_flag_a_o = overflow_flag_a;
  assign overflow_flag_b_o = overflow_flag_b;

  // ---------------------------------------------
  // AXI4-Lite read path
  // ---------------------------------------------
  wire [11:0] ra = s_axi_araddr_i[11:0];
  wire [7:0] ctrl_rd = {overflow_flag_b, run_bit_b, overflow_flag_a, run_bit_a, 4'h0};
  wire ra_hit = (ra == DTC_ADDR_CTRL) || (ra == DTC_ADDR_MODE) || (ra == DTC_ADDR_LOW_A)
              || (ra == DTC_ADDR_LOW_B) || (ra == DTC_ADDR_HIGH_A) || (ra == DTC_ADDR_HIGH_B);
  wire [7:0] rd_byte = (ra == DTC_ADDR_CTRL) ? ctrl_rd
                     : (ra == DTC_ADDR_MODE) ? timer_mode_control
                     : (ra == DTC_ADDR_LOW_A) ? low_register_a
                     : (ra == DTC_ADDR_LOW_B) ? low_b
                     : (ra == DTC_ADDR_HIGH_A) ? high_register_a
                     : (ra == DTC_ADDR_HIGH_B) ? high_b : 8'h00;
  assign s_axi_arready_o = !s_axi_rvalid_o;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0;
      s_axi_rresp_o <= DTC_RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= {24'h00_0000, rd_byte};
      s_axi_rresp_o <= ra_hit ? DTC_RESP_OKAY : DTC_RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // ---------------------------------------------
  // Assertions
  // ---------------------------------------------
  wire wr_any_a = wr_b0 && (wa_la || wa_ha);
  AST_MC_PERIOD: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_01]
    upd |=> !upd [*8] ##1 !upd [*3] ##1 upd)
    else $error("update phase not every 12 clocks");
  AST_SAMPLE_TO_UPDATE: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_02]
    smp |-> ##7 upd) else $error("sample and update phases misplaced");
  AST_EDGE_COUNT: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_03]
    fall_a && mode_a == DTC_M_16BIT && timer_mode_control[DTC_CT_A] && en_a
    ##7 (upd && en_a && !wr_any_a && !wr_b0)
    |=> {high_register_a, low_register_a} == $past({high_register_a, low_register_a}) + 16'h1)
    else $error("edge not counted at next update");
  AST_GATED_HOLD: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_07]
    !en_a && !split && !wr_any_a |=> $stable(low_register_a) && $stable(high_register_a))
    else $error("timer a moved while disabled");
  AST_RELOAD: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_13]
    tick_a && mode_a == DTC_M_RELOAD && low_register_a == 8'hff && !wr_any_a
    |=> low_register_a == $past(high_register_a) && $stable(high_register_a) && overflow_flag_a) // [RULE_18]
    else $error("reload wrong");
  AST_PRESCALE: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_10]
    tick_a && mode_a == DTC_M_13BIT && low_register_a[4:0] == 5'h1f && !wr_any_a
    |=> high_register_a == $past(high_register_a) + 8'h1 && low_register_a[4:0] == 5'h00)
    else $error("prescaler carry wrong");
  AST_B_STOPPED: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_15]
    mode_b == DTC_M_SPLIT && !(wr_b0 && (wa_lb || wa_hb)) |=> $stable(low_b) && $stable(high_b))
    else $error("timer b counted in mode 11");
  AST_FLAG_STICKY: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_21]
    overflow_flag_a && !wr_ctrl && !flag_ack_a_i |=> overflow_flag_a) else $error("flag a lost");
  AST_SPLIT_FLAG_B: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_19]
    tick_ha && high_register_a == 8'hff |=> overflow_flag_b) else $error("split high overflow missed");
  // Count path properties
  AST_TIMER_TICK: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_01] [RULE_06]
    upd && en_a && !timer_mode_control[DTC_CT_A] && mode_a == DTC_M_16BIT && !wr_any_a
    |=> {high_register_a, low_register_a} == $past({high_register_a, low_register_a}) + 16'h1)
    else $error("timer a missed a machine cycle");
  AST_NO_PIN_EDGE: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_02]
    upd && timer_mode_control[DTC_CT_A] && !pend_a && !split && !wr_any_a
    |=> $stable(low_register_a) && $stable(high_register_a))
    else $error("counter a moved without a pin edge");
  AST_RUN_KEEPS: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_17]
    wr_ctrl && !run_bit_a && wd[DTC_RUN_A] && !split
    |=> $stable(low_register_a) && $stable(high_register_a))
    else $error("starting timer a changed its count");
  AST_GATE_B: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_07]
    !en_b && !(wr_b0 && (wa_lb || wa_hb)) |=> $stable(low_b) && $stable(high_b))
    else $error("timer b moved while disabled");
  AST_SPLIT_HIGH: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_14]
    tick_ha && !(wr_b0 && wa_ha) |=> high_register_a == $past(high_register_a) + 8'h1)
    else $error("split high timer missed a machine cycle");
  AST_SPLIT_B_RUNS: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_20]
    split && upd && (mode_b == DTC_M_13BIT || mode_b == DTC_M_16BIT) && !timer_mode_control[DTC_CT_B]
    && !(wr_b0 && (wa_lb || wa_hb)) |=> low_b != $past(low_b))
    else $error("timer b idle outside its stop mode");
  COV_RELOAD: cover property (@(posedge clk_i) tick_a && mode_a == DTC_M_RELOAD && low_register_a == 8'hff);
  COV_EDGE: cover property (@(posedge clk_i) fall_a ##7 tick_a);
  COV_SPLIT_OVF: cover property (@(posedge clk_i) ovf_ha);
  COV_B_OVF: cover property (@(posedge clk_i) tick_b && step_b[16]);
  COV_SPLIT_B_RUN: cover property (@(posedge clk_i) split && upd && mode_b == DTC_M_13BIT);
endmodule : dtc_top
`default_nettype wire

// ### test/dtc_pin_model.sv
`default_nettype none
module dtc_pin_model
  import dtc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Commands from the bench
  input wire logic burst_i,
  input wire logic gate_a_i,
  input wire logic gate_b_i,
  // Pins toward the block
  output logic count_pin_a_o,
  output logic count_pin_b_o,
  output logic gate_pin_a_o,
  output logic gate_pin_b_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Count source, one machine cycle per level
  // ----------------------------------------
  logic [3:0] hold;
  logic level;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      hold <= 4'h0;
      level <= 1'b1;
    end else if (burst_i || !level) begin
      if (hold == DTC_PH_LAST) begin
        hold <= 4'h0;
        level <= ~level;
      end else begin
        hold <= hold + 4'h1;
      end
    end else begin
      hold <= 4'h0;
    end
  end
  assign count_pin_a_o = level;
  assign count_pin_b_o = level;
  assign gate_pin_a_o = gate_a_i;
  assign gate_pin_b_o = gate_b_i;
endmodule : dtc_pin_model
`default_nettype wire

// ### test/tb.sv
`default_nettype none
module tb
  import dtc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic burst = 1'b0, gate_a = 1'b0, gate_b = 1'b0, ack_a = 1'b0, ack_b = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, ovf_a, ovf_b, cpa, cpb, gpa, gpb;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic fa, fb;
  int cyc = 0;
  int n_mismatch = 0;
  int tests_run = 0;
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;
  dtc_top DUT (.clk_i(clk_i), .reset_i(reset_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'h1), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .count_pin_a_i(cpa),
    .count_pin_b_i(cpb), .gate_pin_a_i(gpa), .gate_pin_b_i(gpb), .flag_ack_a_i(ack_a),
    .flag_ack_b_i(ack_b), .overflow_flag_a_o(ovf_a), .overflow_flag_b_o(ovf_b));
  dtc_pin_model partner (.clk_i(clk_i), .reset_i(reset_i), .burst_i(burst), .gate_a_i(gate_a),
    .gate_b_i(gate_b), .count_pin_a_o(cpa), .count_pin_b_o(cpb), .gate_pin_a_o(gpa), .gate_pin_b_o(gpb));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      n_mismatch++;
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = DTC_RESP_OKAY);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    check({30'h0000_0000, bresp}, {30'h0000_0000, er});
    bready <= 1'b0;
    @(posedge clk_i);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er = DTC_RESP_OKAY);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    check(rdata, exp);
    check({30'h0000_0000, rresp}, {30'h0000_0000, er});
    rready <= 1'b0;
    @(posedge clk_i);
  endtask : rd
  // Register written to on, held exactly k machine cycles, then to off
  task automatic win(input logic [11:0] a, input logic [7:0] on, input logic [7:0] off, input int k);
    int t0;
    t0 = cyc;
    wr(a, on);
    while (cyc < t0 + 12 * k) @(posedge clk_i);
    fa = ovf_a;
    fb = ovf_b;
    wr(a, off);
  endtask : win
  task automatic load(input logic [7:0] mode, input logic [7:0] lo, input logic [7:0] hi);
    wr(DTC_ADDR_MODE, mode);
    wr(DTC_ADDR_LOW_A, lo);
    wr(DTC_ADDR_HIGH_A, hi);
  endtask : load
  task automatic final_report();
    $display("counts: %0d mismatches in %0d comparisons", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    rd(DTC_ADDR_MODE, 32'h0000_0000);
    rd(DTC_ADDR_CTRL, 32'h0000_0000);
    wr(DTC_ADDR_MODE, 8'ha5);
    rd(DTC_ADDR_MODE, 32'h0000_00a5);
    rd(12'h0ffc, 32'h0000_0000, DTC_RESP_SLVERR);
    wr(12'h0ffc, 8'h11, DTC_RESP_SLVERR);
    rd(DTC_ADDR_MODE, 32'h0000_00a5);
    $display("test regs done");
  endtask : t_regs
  task automatic t_modes();
    load(8'h01, 8'hfe, 8'hff);
    win(DTC_ADDR_CTRL, 8'h10, 8'h00, 5);
    rd(DTC_ADDR_LOW_A, 32'h0000_0003);
    rd(DTC_ADDR_HIGH_A, 32'h0000_0000);
    check({30'h0, fa, fb}, 32'h0000_0002);
    load(8'h00, 8'hfe, 8'h05);
    win(DTC_ADDR_CTRL, 8'h10, 8'h00, 3);
    rd(DTC_ADDR_LOW_A, 32'h0000_00e1);
    rd(DTC_ADDR_HIGH_A, 32'h0000_0006);
    load(8'h02, 8'hfe, 8'hf0);
    win(DTC_ADDR_CTRL, 8'h10, 8'h00, 5);
    rd(DTC_ADDR_LOW_A, 32'h0000_00f3);
    rd(DTC_ADDR_HIGH_A, 32'h0000_00f0);
    check({31'h0, fa}, 32'h0000_0001);
    $display("test modes done");
  endtask : t_modes
  task automatic t_gate();
    load(8'h09, 8'h00, 8'h00);
    win(DTC_ADDR_CTRL, 8'h10, 8'h00, 4);
    rd(DTC_ADDR_LOW_A, 32'h0000_0000);
    gate_a <= 1'b1;
    win(DTC_ADDR_CTRL, 8'h10, 8'h00, 4);
    rd(DTC_ADDR_LOW_A, 32'h0000_0004);
    $display("test gate done");
  endtask : t_gate
  task automatic t_counter();
    load(8'h55, 8'h00, 8'h00);
    wr(DTC_ADDR_LOW_B, 8'hf8);
    wr(DTC_ADDR_HIGH_B, 8'hff);
    wr(DTC_ADDR_CTRL, 8'h50);
    burst <= 1'b1;
    repeat (234) @(posedge clk_i);
    burst <= 1'b0;
    repeat (48) @(posedge clk_i);
    rd(DTC_ADDR_LOW_A, 32'h0000_000a);
    rd(DTC_ADDR_LOW_B, 32'h0000_0002);
    rd(DTC_ADDR_HIGH_B, 32'h0000_0000);
    check({30'h0, ovf_a, ovf_b}, 32'h0000_0001);
    wr(DTC_ADDR_CTRL, 8'h00);
    $display("test counter done");
  endtask : t_counter
  task automatic t_split();
    load(8'h33, 8'h00, 8'hff);
    wr(DTC_ADDR_LOW_B, 8'h00);
    win(DTC_ADDR_CTRL, 8'h40, 8'h00, 2);
    rd(DTC_ADDR_HIGH_A, 32'h0000_0001);
    check({30'h0, fa, fb}, 32'h0000_0001);
    rd(DTC_ADDR_LOW_A, 32'h0000_0000);
    rd(DTC_ADDR_LOW_B, 32'h0000_0000);
    win(DTC_ADDR_MODE, 8'h03, 8'h33, 3);
    rd(DTC_ADDR_LOW_B, 32'h0000_0003);
    $display("test split done");
  endtask : t_split
  task automatic t_flags();
    wr(DTC_ADDR_CTRL, 8'ha0);
    check({30'h0, ovf_a, ovf_b}, 32'h0000_0003);
    ack_a <= 1'b1;
    ack_b <= 1'b1;
    @(posedge clk_i);
    ack_a <= 1'b0;
    ack_b <= 1'b0;
    @(posedge clk_i);
    check({30'h0, ovf_a, ovf_b}, 32'h0000_0000);
    rd(DTC_ADDR_CTRL, 32'h0000_0000);
    $display("test flags done");
  endtask : t_flags
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_modes();
    t_gate();
    t_counter();
    t_split();
    t_flags();
    final_report();
  end
  initial begin
    #100000;
    $display("watchdog expired");
    n_mismatch++;
    final_report();
  end
endmodule : tb
`default_nettype wire
